/* File: dv/tb_top.sv */
/* Self-checking bench for the interpreter.
   Assumes the host model and the bound checker. */
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0, rst_n = 1'b0, guard = 1'b0, slow = 1'b0;
  logic [7:0] own = 8'h5A;
  int error_cnt = 0, compares = 0, cyc = 0;
  wdcfg_pkg::wdcfg_char_t rx, tx;
  wdcfg_pkg::wdcfg_cfg_t  cfg;
  logic [7:0] st;
  logic [127:0] ct;
  logic rdy;
  wdcfg_top i_dut (.clk(clk), .rst_n(rst_n), .station_address(own), .rx_char(rx),
    .tx_ready(rdy), .guard_expired(guard), .tx_char(tx), .cfg(cfg), .slot_trip(st),
    .chan_trip(ct));
  wdcfg_host i_host (.clk(clk), .slow(slow), .tx_char(tx), .rx_char(rx), .tx_ready(rdy));
  always #4 clk = ~clk;
  task automatic conclude();
    $display("checks %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude
  // Hang guard: far above the several hundred cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      conclude();
    end
  end
  task automatic check(input logic [127:0] got, input logic [127:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  function automatic logic [127:0] pk(input string s);
    pk = '0;
    for (int i = 0; i < s.len(); i++) pk = {pk[119:0], s[i]};
  endfunction : pk
  // Send a frame and compare the whole reply; empty means silence
  task automatic cmd(input string c, input string r);
    logic [127:0] g;
    g = '0;
    i_host.send(c);
    i_host.get();
    foreach (i_host.q[i]) g = {g[119:0], i_host.q[i]};
    check(g, (r == "") ? 128'h0 : pk({r, "\r"}));
  endtask : cmd
  // Stalling host on set and get of the timeout
  task automatic t_timeout();
    slow = 1'b1;
    cmd("$5AX1234", "!5A");
    check(128'(cfg.timeout), 128'h1234);
    cmd("$5AXR", "!5A1234");
    slow = 1'b0;
  endtask : t_timeout
  task automatic t_slot();
    cmd("$5AXEWA5", "!5A");
    cmd("$5AXEWG1", "?5A");
    cmd("$5A$5AXER", "!5AA5");
    @(posedge clk) #1 guard = 1'b1;
    repeat (2) @(posedge clk);
    #1 check(128'(st), 128'hA5);
    guard = 1'b0;
  endtask : t_slot
  task automatic t_chan();
    cmd("$5AXS3D8001", "!5A");
    cmd("$5AXS9DFFFF", "?5A");
    cmd("$5AXS3", "!5A8001");
    cmd("$5AXS9", "?5A");
    @(posedge clk) #1 guard = 1'b1;
    repeat (2) @(posedge clk);
    #1 check(128'({ct[63:48], ct[15:0]}), 128'h8001_0000);
    guard = 1'b0;
  endtask : t_chan
  // Foreign address and unknown opcode both stay silent
  task automatic t_silent();
    cmd("$5BXR", "");
    cmd("$5AXQ", "");
    cmd("$5AX12345678901", "");
    check(128'(cfg), 128'h1234_A5);
    // Move the station: the new address answers, the old one goes quiet
    own = 8'h03;
    cmd("$03XR", "!031234");
    cmd("$5AXR", "");
    own = 8'h5A;
  endtask : t_silent
  // Mid-run reset must clear every stored setting and the slot trip output
  task automatic t_reset();
    @(posedge clk) #1 rst_n = 1'b0;
    repeat (3) @(posedge clk);
    #1 check(128'({cfg, st}), 128'h0);
    rst_n = 1'b1;
    cmd("$5AXR", "!5A0000");
    cmd("$5AXER", "!5A00");
    cmd("$5AXS3", "!5A0000");
  endtask : t_reset
  initial begin
    repeat (3) @(posedge clk);
    #1 rst_n = 1'b1;
    t_timeout();
    t_slot();
    t_chan();
    t_silent();
    t_reset();
    conclude();
  end
endmodule : tb_top
`default_nettype wire

/* File: dv/wdcfg_host.sv */
/* Host model: sends ASCII frames, collects replies.
   Assumes one clock shared with the interpreter. */
`default_nettype none
module wdcfg_host (
  input  wire logic                   clk,
  input  wire logic                   slow,
  input  wire wdcfg_pkg::wdcfg_char_t tx_char,
  output var  wdcfg_pkg::wdcfg_char_t rx_char,
  output var  logic                   tx_ready
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] q[$];
  logic [1:0] ph = 2'h0;
  initial rx_char = '0;
  // Slow mode refuses one cycle in four, so replies must wait on us
  assign tx_ready = !slow || (ph != 2'h0);
  always @(posedge clk) begin
    ph <= ph + 2'h1;
    if (tx_char.valid) q.push_back(tx_char.data);
  end
  // One char per cycle, closed by CR; idle data is inverted junk
  task automatic send(input string s);
    logic [7:0] ch;
    q.delete();
    for (int i = 0; i <= s.len(); i++) begin
      ch = (i == s.len()) ? wdcfg_pkg::CHR_CR : s[i];
      @(posedge clk) #1 rx_char = {1'b1, ch};
    end
    @(posedge clk) #1 rx_char = {1'b0, ~ch};
  endtask : send
  // Wait for a reply to end in CR, bounded; silence just runs out
  task automatic get();
    for (int i = 0; i < 60; i++) begin
      @(posedge clk) #1;
      if (q.size() > 0 && q[q.size()-1] == wdcfg_pkg::CHR_CR) break;
    end
  endtask : get
endmodule : wdcfg_host
`default_nettype wire

/* File: dv/wdcfg_top_sva.sv */
/* Port checker for the interpreter.
   Assumes bind onto every wdcfg_top instance. */
`default_nettype none
module wdcfg_top_sva #(parameter int NSLOT = 8) (
  input wire logic                   clk,
  input wire logic                   rst_n,
  input wire logic [7:0]             station_address,
  input wire wdcfg_pkg::wdcfg_char_t rx_char,
  input wire logic                   tx_ready,
  input wire logic                   guard_expired,
  input wire wdcfg_pkg::wdcfg_char_t tx_char,
  input wire wdcfg_pkg::wdcfg_cfg_t  cfg,
  input wire logic [NSLOT-1:0]       slot_trip,
  input wire logic [NSLOT*16-1:0]    chan_trip
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_TX_AFTER_READY: assert property (tx_char.valid |-> $past(tx_ready))
    else $error("tx char sent without ready");
  AST_TX_CHARSET: assert property (tx_char.valid |-> tx_char.data inside {8'h21, 8'h3F,
    8'h0D, [8'h30:8'h39], [8'h41:8'h46], [8'h61:8'h66]}) else $error("illegal reply char");
  AST_CFG_AFTER_CR: assert property ($changed(cfg) |->
    $past(rx_char.valid) && $past(rx_char.data) == 8'h0D)
    else $error("cfg changed without CR");
  AST_SLOT_TRIP: assert property (slot_trip == ({NSLOT{$past(guard_expired)}} &
    NSLOT'($past(cfg.slot_mask)))) else $error("slot trip mismatch");
  AST_CHAN_IDLE: assert property (!$past(guard_expired) |-> chan_trip == '0)
    else $error("channel trip without expiry");
  AST_CR_GAP: assert property (tx_char.valid && tx_char.data == 8'h0D |=> !tx_char.valid)
    else $error("char after reply CR");
  AST_HEAD_NEXT: assert property (tx_char.valid && tx_char.data inside {8'h21, 8'h3F}
    |-> ##[1:40] tx_char.valid) else $error("reply stalled after head");
  AST_REPLY_END: assert property (tx_char.valid && tx_char.data == 8'h21
    |-> ##[2:60] (tx_char.valid && tx_char.data == 8'h0D)) else $error("reply lacks CR");
endmodule : wdcfg_top_sva
bind wdcfg_top wdcfg_top_sva #(.NSLOT(NSLOT)) i_sva (.clk(clk), .rst_n(rst_n),
  .station_address(station_address), .rx_char(rx_char), .tx_ready(tx_ready),
  .guard_expired(guard_expired), .tx_char(tx_char), .cfg(cfg), .slot_trip(slot_trip),
  .chan_trip(chan_trip));
`default_nettype wire

/* File: hdl/wdcfg_hex.sv */
/*
 * Hex digit decoder: one ASCII character to a nibble plus a valid flag.
 * Assumes purely combinational use by the interpreter.
 */
`default_nettype none
module wdcfg_hex (
  input  wire logic [7:0] chr,
  output logic      [3:0] nib,
  output logic            ok
);
  // Accept 0-9, A-F and a-f; anything else is a syntax error
  always_comb begin
    nib = 4'h0;
    ok  = 1'b1;
    if (chr >= 8'h30 && chr <= 8'h39) begin
      nib = chr[3:0];
    end else if ((chr >= 8'h41 && chr <= 8'h46) || (chr >= 8'h61 && chr <= 8'h66)) begin
      nib = 4'(chr[3:0] + 4'h9);
    end else begin
      ok = 1'b0;
    end
  end
endmodule : wdcfg_hex
`default_nettype wire

/* File: hdl/wdcfg_pkg.sv */
/*
 * Shared constants and carrier types for the expiry guard command interpreter.
 * Assumes byte-wide characters arrive already deframed from a serial receiver.
 */
`default_nettype none
package wdcfg_pkg;
  localparam int  NUM_SLOTS       = 8;
  localparam int  RX_BUF_LEN      = 12;
  localparam int  TX_BUF_LEN      = 8;
  localparam logic [7:0] CHR_CR     = 8'h0D;
  localparam logic [7:0] CHR_DOLLAR = 8'h24;
  localparam logic [7:0] CHR_BANG   = 8'h21;
  localparam logic [7:0] CHR_QUERY  = 8'h3F;
  localparam logic [7:0] CHR_X      = 8'h58;
  localparam logic [7:0] CHR_R      = 8'h52;
  localparam logic [7:0] CHR_E      = 8'h45;
  localparam logic [7:0] CHR_W      = 8'h57;
  localparam logic [7:0] CHR_S      = 8'h53;
  localparam logic [7:0] CHR_D      = 8'h44;
  localparam logic [15:0] TIMEOUT_RST   = 16'h0000;
  localparam logic [7:0]  SLOT_MASK_RST = 8'h00;
  localparam logic [15:0] CHAN_MASK_RST = 16'h0000;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } wdcfg_char_t;

  typedef struct packed {
    logic [15:0] timeout;
    logic [7:0]  slot_mask;
  } wdcfg_cfg_t;
endpackage : wdcfg_pkg
`default_nettype wire

/* File: hdl/wdcfg_top.sv */
/*
 * Expiry guard configuration command interpreter: collects one frame, checks
 * it, stores timeout and masks, and streams back a reply.
 * Assumes a UART outside: rx chars on a one-cycle strobe, tx_ready handshake.
 */
`default_nettype none
module wdcfg_top #(
  parameter int NSLOT = wdcfg_pkg::NUM_SLOTS
) (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire logic [7:0]             station_address,
  input  wire wdcfg_pkg::wdcfg_char_t rx_char,
  input  wire logic                   tx_ready,
  input  wire logic                   guard_expired,
  output var  wdcfg_pkg::wdcfg_char_t tx_char,
  output var  wdcfg_pkg::wdcfg_cfg_t  cfg,
  output logic [NSLOT-1:0]            slot_trip,
  output logic [NSLOT*16-1:0]         chan_trip
);
  localparam int RXL = wdcfg_pkg::RX_BUF_LEN;
  localparam int TXL = wdcfg_pkg::TX_BUF_LEN;

  typedef enum logic [1:0] {WDCFG_IDLE, WDCFG_COLLECT, WDCFG_SEND} wdcfg_state_t;

  wdcfg_state_t            st_q, st_d;
  logic [7:0]              rxb_q [RXL];
  logic [7:0]              rxb_d [RXL];
  logic [3:0]              rlen_q, rlen_d;
  logic                    ovf_q, ovf_d;
  logic [7:0]              txb_q [TXL];
  logic [7:0]              txb_d [TXL];
  logic [3:0]              tlen_q, tlen_d, tpos_q, tpos_d;
  wdcfg_pkg::wdcfg_char_t  tx_q, tx_d;
  wdcfg_pkg::wdcfg_cfg_t   cfg_q, cfg_d;
  logic [15:0]             chm_q [NSLOT];
  logic [15:0]             chm_d [NSLOT];
  logic [NSLOT-1:0]        strip_q, strip_d;
  logic [NSLOT*16-1:0]     ctrip_q, ctrip_d;

  // Hex decode of every one of the twelve receive buffer positions
  logic [3:0] nib [RXL];
  logic       hok [RXL];
  for (genvar g = 0; g < RXL; g++) begin : g_hex
    wdcfg_hex u_hex (
      .chr (rxb_q[g]),
      .nib (nib[g]),
      .ok  (hok[g])
    );
  end

  function automatic logic [7:0] to_hex(input logic [3:0] n);
    to_hex = (n < 4'hA) ? {4'h3, n} : 8'(8'h37 + {4'h0, n});
  endfunction : to_hex

  function automatic logic [3:0] slot_of(input logic [7:0] c);
    slot_of = c[3:0];
  endfunction : slot_of

  function automatic logic slot_ok(input logic [7:0] c);
    slot_ok = (c >= 8'h30) && (c < 8'(8'h30 + NSLOT)) && (c <= 8'h39);
  endfunction : slot_ok

  // Frame collection, decode, config update and reply streaming
  always_comb begin
    logic       addr_ok;
    logic       reply;
    logic       good;
    logic [3:0] sl;
    addr_ok = 1'b0;
    reply   = 1'b0;
    good    = 1'b0;
    sl      = 4'h0;
    st_d    = st_q;
    rxb_d   = rxb_q;
    rlen_d  = rlen_q;
    ovf_d   = ovf_q;
    txb_d   = txb_q;
    tlen_d  = tlen_q;
    tpos_d  = tpos_q;
    tx_d    = '0;
    cfg_d   = cfg_q;
    chm_d   = chm_q;
    case (st_q)
      WDCFG_IDLE: begin
        if (rx_char.valid && rx_char.data == wdcfg_pkg::CHR_DOLLAR) begin
          st_d   = WDCFG_COLLECT;
          rlen_d = 4'h0;
          ovf_d  = 1'b0;
        end
      end
      WDCFG_COLLECT: begin
        if (rx_char.valid && rx_char.data == wdcfg_pkg::CHR_CR) begin
          st_d = WDCFG_IDLE;
          addr_ok = !ovf_q && rlen_q >= 4'd3 && hok[0] && hok[1]
                    && {nib[0], nib[1]} == station_address;
          if (addr_ok && rxb_q[2] == wdcfg_pkg::CHR_X) begin
            if (rlen_q == 4'd4 && rxb_q[3] == wdcfg_pkg::CHR_R) begin
              reply = 1'b1;
              good  = 1'b1;
              for (int k = 0; k < 4; k++)
                txb_d[3+k] = to_hex(cfg_q.timeout[15-4*k -: 4]);
              tlen_d = 4'd7;   // CR goes out after head, address and four digits
            end else if (rlen_q == 4'd7 && hok[3] && hok[4] && hok[5] && hok[6]) begin
              reply = 1'b1;
              good  = 1'b1;
              cfg_d.timeout = {nib[3], nib[4], nib[5], nib[6]};
            end else if (rlen_q == 4'd5 && rxb_q[3] == wdcfg_pkg::CHR_E
                         && rxb_q[4] == wdcfg_pkg::CHR_R) begin
              reply = 1'b1;
              good  = 1'b1;
              txb_d[3] = to_hex(cfg_q.slot_mask[7:4]);
              txb_d[4] = to_hex(cfg_q.slot_mask[3:0]);
              tlen_d   = 4'd5;
            end else if (rlen_q == 4'd7 && rxb_q[3] == wdcfg_pkg::CHR_E
                         && rxb_q[4] == wdcfg_pkg::CHR_W) begin
              reply = 1'b1;
              good  = hok[5] && hok[6];
              if (good) cfg_d.slot_mask = {nib[5], nib[6]};
            end else if (rxb_q[3] == wdcfg_pkg::CHR_S && (rlen_q == 4'd5 || rlen_q == 4'd10)) begin
              reply = 1'b1;
              sl    = slot_of(rxb_q[4]);
              if (rlen_q == 4'd5) begin
                good = slot_ok(rxb_q[4]);
                for (int k = 0; k < 4; k++)
                  txb_d[3+k] = to_hex(chm_q[sl[$clog2(NSLOT)-1:0]][15-4*k -: 4]);
                tlen_d = 4'd7;
              end else begin
                good = slot_ok(rxb_q[4]) && rxb_q[5] == wdcfg_pkg::CHR_D
                       && hok[6] && hok[7] && hok[8] && hok[9] && rlen_q == 4'd10;
                if (good)
                  chm_d[sl[$clog2(NSLOT)-1:0]] = {nib[6], nib[7], nib[8], nib[9]};
              end
            end
          end
          // Malformed or foreign frames stay silent; a wrong slot or mask field gets '?'
          if (reply) begin
            st_d     = WDCFG_SEND;
            tpos_d   = 4'h0;
            txb_d[0] = good ? wdcfg_pkg::CHR_BANG : wdcfg_pkg::CHR_QUERY;
            txb_d[1] = rxb_q[0];
            txb_d[2] = rxb_q[1];
            if (!good || tlen_d == 4'h0) tlen_d = 4'd3;
          end
        end else if (rx_char.valid && rx_char.data == wdcfg_pkg::CHR_DOLLAR) begin
          rlen_d = 4'h0;   // A fresh start character resynchronises
          ovf_d  = 1'b0;
        end else if (rx_char.valid) begin
          if (rlen_q < 4'(RXL)) begin
            rxb_d[rlen_q] = rx_char.data;
            rlen_d = 4'(rlen_q + 4'h1);
          end else begin
            ovf_d = 1'b1;
          end
        end
      end
      WDCFG_SEND: begin
        // Characters received while replying are dropped; half-duplex line
        if (tx_ready) begin
          tx_d.valid = 1'b1;
          tx_d.data  = (tpos_q == tlen_q) ? wdcfg_pkg::CHR_CR : txb_q[tpos_q[2:0]];
          tpos_d     = 4'(tpos_q + 4'h1);
          if (tpos_q == tlen_q) begin
            st_d   = WDCFG_IDLE;
            tlen_d = 4'h0;
          end
        end
      end
      default: st_d = WDCFG_IDLE;
    endcase
  end

  // Expiry fan-out: only enabled slots and channels take the timeout action
  always_comb begin
    for (int s = 0; s < NSLOT; s++) begin
      strip_d[s]             = guard_expired & cfg_q.slot_mask[s % 8];
      ctrip_d[s*16 +: 16]    = {16{guard_expired}} & chm_q[s];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q    <= WDCFG_IDLE;
      rlen_q  <= 4'h0;
      ovf_q   <= 1'b0;
      tlen_q  <= 4'h0;
      tpos_q  <= 4'h0;
      tx_q    <= '0;
      cfg_q   <= '{timeout: wdcfg_pkg::TIMEOUT_RST, slot_mask: wdcfg_pkg::SLOT_MASK_RST};
      strip_q <= '0;
      ctrip_q <= '0;
      for (int i = 0; i < RXL; i++) rxb_q[i] <= 8'h00;
      for (int i = 0; i < TXL; i++) txb_q[i] <= 8'h00;
      for (int i = 0; i < NSLOT; i++) chm_q[i] <= wdcfg_pkg::CHAN_MASK_RST;
    end else begin
      st_q    <= st_d;
      rxb_q   <= rxb_d;
      rlen_q  <= rlen_d;
      ovf_q   <= ovf_d;
      txb_q   <= txb_d;
      tlen_q  <= tlen_d;
      tpos_q  <= tpos_d;
      tx_q    <= tx_d;
      cfg_q   <= cfg_d;
      chm_q   <= chm_d;
      strip_q <= strip_d;
      ctrip_q <= ctrip_d;
    end
  end

  assign tx_char   = tx_q;
  assign cfg       = cfg_q;
  assign slot_trip = strip_q;
  assign chan_trip = ctrip_q;
endmodule : wdcfg_top
`default_nettype wire
